// file: uhb_pkg.sv
`default_nettype none
package uhb_pkg;
  // Class request codes.
  localparam logic [7:0] RT_GET = 8'hA1;
  localparam logic [7:0] RT_SET = 8'h21;
  localparam logic [7:0] RQ_GET = 8'h01;
  localparam logic [7:0] RQ_SET = 8'h09;
  localparam logic [15:0] WV_INPUT = 16'h0100;
  localparam logic [15:0] WV_FEATURE = 16'h0300;
  localparam logic [15:0] WV_OUTPUT = 16'h0200;
  localparam logic [15:0] WIDX_HID = 16'h0000;
  // Output report opcodes and header sizes.
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_READ = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_WRITE_NS = 8'h03;
  localparam logic [15:0] HDR_BYTES = 16'h0004;
  localparam logic [15:0] IN_HDR = 16'h0003;
  localparam logic [15:0] FEAT_BYTES = 16'h0002;
  // Input report status codes.
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_TIMEOUT = 8'h01;
  localparam logic [7:0] ST_ADDR_NAK = 8'h02;
  localparam logic [7:0] ST_DATA_NAK = 8'h03;
  // Timing: each bus bit is four quarter phases.
  localparam int CLK_KHZ = 250000;
  localparam int FAST_KHZ = 400;
  localparam int SLOW_KHZ = 100;
  localparam int TIMEOUT_MS = 35;
  localparam int QTR_FAST = (CLK_KHZ + 4 * FAST_KHZ - 1) / (4 * FAST_KHZ);
  localparam int QTR_SLOW = (CLK_KHZ + 4 * SLOW_KHZ - 1) / (4 * SLOW_KHZ);
  localparam logic [9:0] QTR_FAST_L = 10'(QTR_FAST);
  localparam logic [9:0] QTR_SLOW_L = 10'(QTR_SLOW);
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  localparam int TMO_W = 24;
  // Decoded control request kinds.
  typedef enum logic [3:0] {
    K_NONE = 4'b0001,
    K_SET = 4'b0010,
    K_GIN = 4'b0100,
    K_GFT = 4'b1000
  } uhb_kind_e;
  // Two-wire engine states.
  typedef enum logic [3:0] {
    I_IDLE = 4'b0001,
    I_START = 4'b0010,
    I_BIT = 4'b0100,
    I_STOP = 4'b1000
  } uhb_ist_e;
  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } uhb_setup_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } uhb_byte_s;
endpackage : uhb_pkg
`default_nettype wire

// file: uhb_bridge.sv
// What this block does
// - Accept GET REPORT A1h/01h and SET REPORT 21h/09h, index zero only.
// - Embedded function takes port number one above the last exposed port.
// - No interrupt OUT; input report served on interrupt IN and control.
// - Feature get and output set travel only on the control endpoint.
// - Idle and protocol requests unsupported; reports carry no report ID.
// - Output report length counts four header bytes and must match data sent.
// - Opcode 01h reads, 02h writes with stop, 03h writes without stop.
// - Opcode, then 7-bit target address, 2-byte length, payload for writes only.
// - Status stage acks a well formed request while the bus is idle, else stalls, ignoring bus result.
// - Stall status when declared lengths exceed bytes actually delivered.
// - Stall data stage when host sends more bytes than declared.
// - Data addresses wrap at the buffer depth, BUF_DEPTH bytes.
// - Drop bytes beyond the setup length and stall.
// - Opcode 00h is stalled.
// - Master waits while a target holds the clock low.
// - Bus runs at 400 kHz after reset, 100 kHz when selected.
// - On L2 suspend the HID side suspends but a write finishes.
// - A running read may be aborted on suspend.
// - Refuse L1 sleep while a transfer runs.
// - Status byte 0 ok, 1 timeout at 35 ms, 2 address NAK, 3 data NAK.
// - Input report NAKs until the transfer ends, then gives status, length, data.
// - Three-byte input report is status and length; a read report adds the data bytes.
// - Feature get returns a fixed two-byte identification constant.
`default_nettype none
module uhb_bridge
  import uhb_pkg::*;
#(
  parameter int EXT_PORTS = 4,
  parameter int BUF_DEPTH = 64,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  // Identification value is arbitrary.
  parameter logic [15:0] FEATURE_ID = 16'h5A3C
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Hub port assignment.
  output logic [7:0] hid_port_num,
  // Setup stage.
  input wire logic setup_valid,
  input wire uhb_setup_s setup,
  output logic setup_stall,
  // Output report data and status stages.
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_stall,
  input wire logic status_req,
  output logic status_ack,
  output logic status_stall,
  // Input report reads.
  input wire logic in_req,
  input wire logic in_on_ctrl,
  output logic in_nak,
  output uhb_byte_s in_byte,
  input wire logic in_ready,
  // Power management.
  input wire logic suspend_l2,
  input wire logic l1_req,
  output logic l1_ack,
  output logic l1_nak,
  output logic hid_suspended,
  // Bus speed select.
  input wire logic slow_100k,
  // Two-wire bus.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_b,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b,
  output logic i2c_busy
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [TMO_W-1:0] TMO_LIM = TMO_W'(TIMEOUT_CYCLES - 1);

  logic [7:0] mem [BUF_DEPTH];
  uhb_kind_e ctl_kind_ff, kind_dec, in_kind;
  uhb_ist_e ist_ff;
  logic [15:0] wlen_ff, rx_cnt_ff, len_ff, pay_off, ptr_ff, left_ff, in_idx_ff, in_lim_ff, in_lim;
  logic [7:0] op_ff, addr_ff, shift_ff, stat_ff, in_data_ff;
  logic [9:0] div_ff, qlim;
  logic [3:0] bit_ff;
  logic [1:0] ph_ff;
  logic [TMO_W-1:0] tmo_ff;
  logic act, set_dat, dat_over, set_ok, start_op, busy, tick, stretch, adv, abort, tmo_hit, rd_store, in_go, in_ok;
  logic setup_stall_ff, over_ff, out_stall_ff, status_ack_ff, status_stall_ff, hid_susp_ff, l1_ack_ff, l1_nak_ff;
  logic is_addr_ff, is_rd_ff, nostop_ff, nak_ff, scl_rel_ff, sda_rel_ff, in_busy_ff, in_feat_ff, in_nak_ff;

  function automatic uhb_kind_e uhb_decode(input uhb_setup_s s);
    uhb_decode = K_NONE;
    if (s.index == WIDX_HID && s.req_type == RT_GET && s.request == RQ_GET && s.value == WV_INPUT) begin
      uhb_decode = K_GIN;
    end else if (s.index == WIDX_HID && s.req_type == RT_GET && s.request == RQ_GET && s.value == WV_FEATURE) begin
      uhb_decode = K_GFT;
    end else if (s.index == WIDX_HID && s.req_type == RT_SET && s.request == RQ_SET && s.value == WV_OUTPUT) begin
      uhb_decode = K_SET;
    end
  endfunction : uhb_decode

  function automatic logic [15:0] rpt_len(input logic [7:0] op, input logic [15:0] len);
    rpt_len = (op == OP_READ) ? HDR_BYTES : HDR_BYTES + len;
  endfunction : rpt_len

  function automatic logic [7:0] in_pick(input logic [15:0] idx, input logic feat);
    logic [15:0] off;
    off = idx - IN_HDR;
    if (feat) begin
      in_pick = (idx == 16'h0000) ? FEATURE_ID[7:0] : FEATURE_ID[15:8];
    end else if (idx == 16'h0000) begin
      in_pick = stat_ff;
    end else if (idx == 16'h0001) begin
      in_pick = len_ff[7:0];
    end else if (idx == 16'h0002) begin
      in_pick = len_ff[15:8];
    end else begin
      in_pick = mem[off[AW-1:0]];
    end
  endfunction : in_pick

  assign hid_port_num = 8'(EXT_PORTS + 1);
  assign act = !hid_susp_ff;
  assign kind_dec = uhb_decode(setup);
  assign busy = (ist_ff != I_IDLE);

  // Setup stage: decode and remember the control request.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_kind_ff <= K_NONE;
      wlen_ff <= 16'h0000;
      setup_stall_ff <= 1'b0;
    end else begin
      setup_stall_ff <= setup_valid && act && (kind_dec == K_NONE);
      if (setup_valid && act) begin
        ctl_kind_ff <= kind_dec;
        wlen_ff <= setup.length;
      end else if (status_req && act) begin
        ctl_kind_ff <= K_NONE;
      end
    end
  end

  // Data stage: parse the output report header and count bytes.
  assign set_dat = out_valid && act && (ctl_kind_ff == K_SET);
  assign dat_over = (rx_cnt_ff >= wlen_ff) || ((rx_cnt_ff >= HDR_BYTES) && (rx_cnt_ff >= rpt_len(op_ff, len_ff)));
  assign pay_off = rx_cnt_ff - HDR_BYTES;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_cnt_ff <= 16'h0000;
      over_ff <= 1'b0;
      op_ff <= OP_NONE;
      addr_ff <= 8'h00;
      len_ff <= 16'h0000;
      out_stall_ff <= 1'b0;
    end else begin
      out_stall_ff <= set_dat && dat_over;
      if (setup_valid && act) begin
        rx_cnt_ff <= 16'h0000;
        over_ff <= 1'b0;
        op_ff <= OP_NONE;
      end else if (set_dat) begin
        if (dat_over) begin
          over_ff <= 1'b1;
        end else begin
          rx_cnt_ff <= rx_cnt_ff + 16'h0001;
          case (rx_cnt_ff)
            16'h0000: op_ff <= out_data;
            16'h0001: addr_ff <= out_data;
            16'h0002: len_ff[7:0] <= out_data;
            16'h0003: len_ff[15:8] <= out_data;
            default: ;
          endcase
        end
      end
    end
  end

  // Status stage: judge the request and that the bus is idle, never the bus outcome.
  assign set_ok = !over_ff && (rx_cnt_ff == wlen_ff) && (rx_cnt_ff == rpt_len(op_ff, len_ff))
    && (op_ff >= OP_READ) && (op_ff <= OP_WRITE_NS) && !busy;
  assign start_op = status_req && act && (ctl_kind_ff == K_SET) && set_ok;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_ack_ff <= 1'b0;
      status_stall_ff <= 1'b0;
    end else begin
      status_ack_ff <= status_req && act && ((ctl_kind_ff != K_SET) || set_ok);
      status_stall_ff <= status_req && act && (ctl_kind_ff == K_SET) && !set_ok;
    end
  end

  // Shared report buffer: write payload in, read data back.
  always_ff @(posedge clk) begin
    if (rd_store) begin
      mem[ptr_ff[AW-1:0]] <= shift_ff;
    end else if (set_dat && !dat_over && (rx_cnt_ff >= HDR_BYTES) && !busy) begin
      mem[pay_off[AW-1:0]] <= out_data;
    end
  end

  // Quarter-bit divider; it restarts while a target holds the released clock line low.
  assign qlim = slow_100k ? QTR_SLOW_L : QTR_FAST_L;
  assign tick = (div_ff >= qlim - 10'd1);
  assign stretch = scl_rel_ff && !scl_i;
  assign adv = tick && !stretch && busy;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_ff <= 10'd0;
    end else if (!busy || stretch || tick) begin
      div_ff <= 10'd0;
    end else begin
      div_ff <= div_ff + 10'd1;
    end
  end

  // Transfer timeout.
  assign tmo_hit = (tmo_ff >= TMO_LIM);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tmo_ff <= '0;
    end else if (!busy) begin
      tmo_ff <= '0;
    end else begin
      tmo_ff <= tmo_ff + TMO_W'(1);
    end
  end

  assign abort = busy && (ist_ff != I_STOP) && (tmo_hit || (suspend_l2 && is_rd_ff));
  assign rd_store = adv && !abort && (ist_ff == I_BIT) && (ph_ff == 2'd3) && (bit_ff == 4'd8) && is_rd_ff && !is_addr_ff;

  // Two-wire master engine.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ist_ff <= I_IDLE;
      ph_ff <= 2'd0;
      bit_ff <= 4'd0;
      shift_ff <= 8'h00;
      ptr_ff <= 16'h0000;
      left_ff <= 16'h0000;
      is_addr_ff <= 1'b0;
      is_rd_ff <= 1'b0;
      nostop_ff <= 1'b0;
      nak_ff <= 1'b0;
      stat_ff <= ST_OK;
      scl_rel_ff <= 1'b1;
      sda_rel_ff <= 1'b1;
    end else if (start_op) begin
      ist_ff <= I_START;
      ph_ff <= 2'd0;
      is_rd_ff <= (op_ff == OP_READ);
      nostop_ff <= (op_ff == OP_WRITE_NS);
      left_ff <= len_ff;
      ptr_ff <= 16'h0000;
      stat_ff <= ST_OK;
      shift_ff <= {addr_ff[6:0], op_ff == OP_READ};
    end else if (abort) begin
      ist_ff <= I_STOP;
      ph_ff <= 2'd0;
      stat_ff <= ST_TIMEOUT;
    end else if (adv) begin
      ph_ff <= ph_ff + 2'd1;
      case (ist_ff)
        I_START: begin
          // Starting with the clock still held low gives a repeated start.
          case (ph_ff)
            2'd0: sda_rel_ff <= 1'b1;
            2'd1: scl_rel_ff <= 1'b1;
            2'd2: sda_rel_ff <= 1'b0;
            default: begin
              scl_rel_ff <= 1'b0;
              ist_ff <= I_BIT;
              bit_ff <= 4'd0;
              is_addr_ff <= 1'b1;
            end
          endcase
        end
        I_BIT: begin
          case (ph_ff)
            2'd0: begin
              if (bit_ff == 4'd8) begin
                sda_rel_ff <= (is_addr_ff || !is_rd_ff) ? 1'b1 : (left_ff == 16'h0001);
              end else begin
                sda_rel_ff <= (is_addr_ff || !is_rd_ff) ? shift_ff[7] : 1'b1;
              end
            end
            2'd1: scl_rel_ff <= 1'b1;
            2'd2: begin
              if (bit_ff == 4'd8) begin
                nak_ff <= sda_i;
              end else begin
                shift_ff <= {shift_ff[6:0], sda_i};
              end
            end
            default: begin
              scl_rel_ff <= 1'b0;
              if (bit_ff != 4'd8) begin
                bit_ff <= bit_ff + 4'd1;
              end else begin
                bit_ff <= 4'd0;
                is_addr_ff <= 1'b0;
                if ((is_addr_ff || !is_rd_ff) && nak_ff) begin
                  stat_ff <= is_addr_ff ? ST_ADDR_NAK : ST_DATA_NAK;
                  ist_ff <= I_STOP;
                end else if (is_rd_ff && !is_addr_ff) begin
                  ptr_ff <= ptr_ff + 16'h0001;
                  left_ff <= left_ff - 16'h0001;
                  if (left_ff == 16'h0001) begin
                    ist_ff <= I_STOP;
                  end
                end else if (left_ff == 16'h0000) begin
                  ist_ff <= nostop_ff ? I_IDLE : I_STOP;
                end else if (!is_rd_ff) begin
                  shift_ff <= mem[ptr_ff[AW-1:0]];
                  ptr_ff <= ptr_ff + 16'h0001;
                  left_ff <= left_ff - 16'h0001;
                end
              end
            end
          endcase
        end
        I_STOP: begin
          case (ph_ff)
            2'd0: begin
              scl_rel_ff <= 1'b0;
              sda_rel_ff <= 1'b0;
            end
            2'd1: scl_rel_ff <= 1'b1;
            2'd2: sda_rel_ff <= 1'b1;
            default: ist_ff <= I_IDLE;
          endcase
        end
        default: ist_ff <= I_IDLE;
      endcase
    end
  end

  // Input reports: the only reply path, interrupt IN or control.
  assign in_kind = in_on_ctrl ? ctl_kind_ff : K_GIN;
  assign in_lim = (in_kind == K_GFT) ? FEAT_BYTES : (in_on_ctrl ? wlen_ff : IN_HDR + (is_rd_ff ? len_ff : 16'h0000));
  assign in_go = in_req && act && !in_busy_ff;
  assign in_ok = !busy && ((in_kind == K_GIN) || (in_kind == K_GFT)) && (in_lim != 16'h0000);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_busy_ff <= 1'b0;
      in_idx_ff <= 16'h0000;
      in_lim_ff <= 16'h0000;
      in_feat_ff <= 1'b0;
      in_data_ff <= 8'h00;
      in_nak_ff <= 1'b0;
    end else begin
      in_nak_ff <= in_go && !in_ok;
      if (in_go && in_ok) begin
        in_busy_ff <= 1'b1;
        in_idx_ff <= 16'h0000;
        in_lim_ff <= in_lim;
        in_feat_ff <= (in_kind == K_GFT);
        in_data_ff <= in_pick(16'h0000, in_kind == K_GFT);
      end else if (in_busy_ff && in_ready) begin
        if (in_idx_ff + 16'h0001 == in_lim_ff) begin
          in_busy_ff <= 1'b0;
        end else begin
          in_idx_ff <= in_idx_ff + 16'h0001;
          in_data_ff <= in_pick(in_idx_ff + 16'h0001, in_feat_ff);
        end
      end
    end
  end

  // Power management.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hid_susp_ff <= 1'b0;
      l1_ack_ff <= 1'b0;
      l1_nak_ff <= 1'b0;
    end else begin
      hid_susp_ff <= suspend_l2;
      l1_ack_ff <= l1_req && act && !busy;
      l1_nak_ff <= l1_req && act && busy;
    end
  end

  assign setup_stall = setup_stall_ff;
  assign out_stall = out_stall_ff;
  assign status_ack = status_ack_ff;
  assign status_stall = status_stall_ff;
  assign in_nak = in_nak_ff;
  assign in_byte = {in_busy_ff, in_data_ff, in_busy_ff && (in_idx_ff + 16'h0001 == in_lim_ff)};
  assign l1_ack = l1_ack_ff;
  assign l1_nak = l1_nak_ff;
  assign hid_suspended = hid_susp_ff;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_b = scl_rel_ff;
  assign sda_oe_b = sda_rel_ff;
  assign i2c_busy = busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_good_status;
    status_req && act && (ctl_kind_ff == K_SET) && set_ok;
  endsequence
  sequence s_ack_pulse;
    status_ack && !status_stall ##1 !status_ack;
  endsequence

  a_port_number: assert property (hid_port_num == 8'(EXT_PORTS + 1))
    else $error("embedded port number wrong");
  a_idle_req_stall: assert property (setup_valid && act && setup.req_type == RT_SET && setup.request == 8'h0A
    |=> setup_stall) else $error("idle request not stalled");
  a_good_ack: assert property (s_good_status |=> s_ack_pulse)
    else $error("valid output report not acked");
  a_short_stall: assert property (status_req && act && ctl_kind_ff == K_SET && rx_cnt_ff != wlen_ff
    |=> status_stall && !status_ack) else $error("short data stage not stalled");
  a_extra_stall: assert property (out_valid && act && ctl_kind_ff == K_SET && rx_cnt_ff >= wlen_ff
    && !setup_valid |=> out_stall && over_ff) else $error("extra byte not stalled");
  a_zero_opcode: assert property (status_req && act && ctl_kind_ff == K_SET && op_ff == OP_NONE
    |=> status_stall) else $error("opcode zero accepted");
  a_stretch_hold: assert property (busy && stretch && !abort && !start_op |=> ph_ff == $past(ph_ff))
    else $error("phase moved while clock held low");
  a_fast_rate: assert property (!slow_100k && !$past(slow_100k) && busy |-> div_ff < QTR_FAST_L)
    else $error("divider beyond fast quarter period");
  a_read_abort: assert property (busy && is_rd_ff && suspend_l2 && ist_ff != I_STOP |=> ist_ff == I_STOP
    && stat_ff == ST_TIMEOUT) else $error("read not aborted on suspend");
  a_l1_refuse: assert property (l1_req && act && busy |=> l1_nak && !l1_ack)
    else $error("sleep accepted during transfer");
  a_busy_nak: assert property (in_req && act && !in_busy_ff && busy |=> in_nak ##1 !in_byte.valid)
    else $error("input report not refused while busy");
endmodule : uhb_bridge
`default_nettype wire

// file: uhb_i2c_target.sv
`default_nettype none
module uhb_i2c_target #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [7:0] RD_BYTE = 8'h5C
) (
  // Wire levels.
  input wire logic scl,
  input wire logic sda,
  // Open-drain pulls.
  output logic scl_low,
  output logic sda_low,
  // Last bytes seen.
  output logic [7:0] got_addr,
  output logic [7:0] got_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic again;
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl);
      b[i] = sda;
    end
  endtask : get_byte
  task automatic serve();
    logic [7:0] b;
    get_byte(b);
    got_addr = b;
    if (b[7:1] != ADDR) return;
    @(negedge scl);
    sda_low = 1'b1;
    @(negedge scl);
    sda_low = 1'b0;
    if (b[0]) begin
      forever begin
        for (int i = 7; i >= 0; i--) begin
          sda_low = ~RD_BYTE[i];
          @(negedge scl);
        end
        sda_low = 1'b0;
        @(posedge scl);
        if (sda !== 1'b0) return;
        @(negedge scl);
      end
    end
    forever begin
      get_byte(b);
      got_data = b;
      @(negedge scl);
      sda_low = 1'b1;
      @(negedge scl);
      sda_low = 1'b0;
      // Hold the clock low for a while after each data byte.
      scl_low = 1'b1;
      #2000;
      scl_low = 1'b0;
    end
  endtask : serve
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    got_addr = 8'h00;
    got_data = 8'h00;
    again = 1'b0;
    forever begin
      if (!again) @(negedge sda iff scl === 1'b1);
      again = 1'b0;
      fork : xfer
        serve();
        @(posedge sda iff scl === 1'b1);
        begin
          @(negedge sda iff scl === 1'b1);
          again = 1'b1;
        end
      join_any
      disable xfer;
      sda_low = 1'b0;
      scl_low = 1'b0;
    end
  end
endmodule : uhb_i2c_target
`default_nettype wire

// file: uhb_bridge_bench.sv
`default_nettype none
module uhb_bridge_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uhb_pkg::*;
  // Identification value is arbitrary.
  localparam logic [15:0] FEAT_ID = 16'h1E7B;
  logic clk, rst_b, setup_valid, out_valid, status_req, in_req, in_on_ctrl, in_ready, suspend_l2;
  logic l1_req, slow_100k, scl_o, sda_o, scl_oe_b, sda_oe_b, i2c_busy, setup_stall, out_stall;
  logic status_ack, status_stall, in_nak, l1_ack, l1_nak, hid_suspended, scl_low, sda_low, scl, sda;
  logic [7:0] hid_port_num, out_data, got_addr, got_data;
  uhb_setup_s setup;
  uhb_byte_s in_byte;
  int n_mismatch = 0;
  int total_checks = 0;
  assign scl = (scl_oe_b ? 1'b1 : scl_o) & ~scl_low;
  assign sda = (sda_oe_b ? 1'b1 : sda_o) & ~sda_low;
  uhb_bridge #(.TIMEOUT_CYCLES(30000), .FEATURE_ID(FEAT_ID)) i_dut (
    .clk(clk), .rst_b(rst_b), .hid_port_num(hid_port_num), .setup_valid(setup_valid), .setup(setup),
    .setup_stall(setup_stall), .out_valid(out_valid), .out_data(out_data), .out_stall(out_stall),
    .status_req(status_req), .status_ack(status_ack), .status_stall(status_stall), .in_req(in_req),
    .in_on_ctrl(in_on_ctrl), .in_nak(in_nak), .in_byte(in_byte), .in_ready(in_ready), .suspend_l2(suspend_l2),
    .l1_req(l1_req), .l1_ack(l1_ack), .l1_nak(l1_nak), .hid_suspended(hid_suspended), .slow_100k(slow_100k),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_b(scl_oe_b), .sda_i(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b),
    .i2c_busy(i2c_busy));
  uhb_i2c_target i_tgt (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low), .got_addr(got_addr),
    .got_data(got_data));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic set_tx(input logic [15:0] len, input logic [7:0] q[$], input int ok, input logic [1:0] st);
    setup = '{RT_SET, RQ_SET, WV_OUTPUT, WIDX_HID, len};
    pulse(setup_valid);
    chk(16'(setup_stall), 16'h0);
    out_valid = 1'b1;
    foreach (q[i]) begin
      out_data = q[i];
      tick(1);
      chk(16'(out_stall), 16'(i >= ok));
    end
    out_valid = 1'b0;
    pulse(status_req);
    chk(16'({status_ack, status_stall}), 16'(st));
  endtask : set_tx
  task automatic get_rep(input logic ctrl, input logic [7:0] q[$]);
    in_on_ctrl = ctrl;
    in_ready = 1'b1;
    pulse(in_req);
    foreach (q[i]) begin
      chk(16'({in_byte.valid, in_byte.last, in_byte.data}), 16'({1'b1, i == q.size() - 1, q[i]}));
      tick(1);
    end
    chk(16'(in_byte.valid), 16'h0);
  endtask : get_rep
  task automatic wait_idle();
    for (int i = 0; i < 40000 && i2c_busy !== 1'b0; i++) begin
      tick(1);
    end
    chk(16'(i2c_busy), 16'h0);
  endtask : wait_idle
  task automatic s_setup();
    uhb_setup_s t[9];
    t = '{'{RT_GET, RQ_GET, WV_INPUT, WIDX_HID, 16'h0003}, '{RT_GET, RQ_GET, WV_FEATURE, WIDX_HID, 16'h0002},
      '{RT_SET, RQ_SET, WV_OUTPUT, WIDX_HID, 16'h0004}, '{RT_GET, RQ_GET, WV_OUTPUT, WIDX_HID, 16'h0004},
      '{RT_SET, RQ_SET, WV_INPUT, WIDX_HID, 16'h0004}, '{RT_GET, RQ_GET, WV_INPUT, 16'h0001, 16'h0003},
      '{RT_GET, 8'h02, 16'h0000, WIDX_HID, 16'h0001}, '{RT_SET, 8'h0A, 16'h0000, WIDX_HID, 16'h0000},
      '{RT_SET, 8'h0B, 16'h0000, WIDX_HID, 16'h0000}};
    for (int i = 0; i < 9; i++) begin
      setup = t[i];
      pulse(setup_valid);
      chk(16'(setup_stall), 16'(i > 2));
      tick(1);
    end
  endtask : s_setup
  task automatic s_write();
    longint t0;
    set_tx(16'h0005, '{OP_WRITE, 8'h50, 8'h01, 8'h00, 8'hAA}, 5, 2'b10);
    chk(16'(i2c_busy), 16'h1);
    pulse(l1_req);
    chk(16'({l1_ack, l1_nak}), 16'h1);
    in_on_ctrl = 1'b0;
    pulse(in_req);
    chk(16'(in_nak), 16'h1);
    @(posedge scl);
    t0 = $time;
    @(posedge scl);
    chk(16'(($time - t0) / 4), 16'(4 * QTR_FAST));
    tick(1);
    wait_idle();
    chk({got_addr, got_data}, 16'hA0AA);
    pulse(l1_req);
    chk(16'({l1_ack, l1_nak}), 16'h2);
    get_rep(1'b0, '{ST_OK, 8'h01, 8'h00});
  endtask : s_write
  task automatic s_read();
    set_tx(16'h0005, '{OP_WRITE_NS, 8'h50, 8'h01, 8'h00, 8'h10}, 5, 2'b10);
    wait_idle();
    chk({7'h00, scl_oe_b, got_data}, 16'h0010);
    set_tx(16'h0004, '{OP_READ, 8'h50, 8'h01, 8'h00}, 4, 2'b10);
    wait_idle();
    chk(16'(got_addr), 16'h00A1);
    setup = '{RT_GET, RQ_GET, WV_INPUT, WIDX_HID, 16'h0004};
    pulse(setup_valid);
    get_rep(1'b1, '{ST_OK, 8'h01, 8'h00, 8'h5C});
    get_rep(1'b0, '{ST_OK, 8'h01, 8'h00, 8'h5C});
  endtask : s_read
  task automatic s_nak();
    longint t0;
    set_tx(16'h0005, '{OP_WRITE, 8'h33, 8'h01, 8'h00, 8'h55}, 5, 2'b10);
    slow_100k = 1'b1;
    @(posedge scl);
    t0 = $time;
    @(posedge scl);
    chk(16'(($time - t0) / 4), 16'(4 * QTR_SLOW));
    tick(1);
    slow_100k = 1'b0;
    wait_idle();
    get_rep(1'b0, '{ST_ADDR_NAK, 8'h01, 8'h00});
  endtask : s_nak
  initial begin
    rst_b = 1'b0;
    {setup_valid, out_valid, status_req, in_req, in_on_ctrl, in_ready, suspend_l2, l1_req, slow_100k} = '0;
    setup = '0;
    out_data = 8'h00;
    tick(3);
    rst_b = 1'b1;
    tick(1);
    chk({hid_port_num, 5'h00, scl_oe_b, sda_oe_b, i2c_busy}, 16'h0506);
    s_setup();
    setup = '{RT_GET, RQ_GET, WV_FEATURE, WIDX_HID, 16'h0002};
    pulse(setup_valid);
    get_rep(1'b1, '{FEAT_ID[7:0], FEAT_ID[15:8]});
    pulse(status_req);
    chk(16'({status_ack, status_stall}), 16'h2);
    set_tx(16'h0004, '{OP_NONE, 8'h50, 8'h00, 8'h00}, 4, 2'b01);
    set_tx(16'h0006, '{OP_WRITE, 8'h50, 8'h02, 8'h00, 8'hAA}, 5, 2'b01);
    set_tx(16'h0005, '{OP_WRITE, 8'h50, 8'h02, 8'h00, 8'hAA}, 5, 2'b01);
    set_tx(16'h0004, '{OP_READ, 8'h50, 8'h01, 8'h00, 8'h77}, 4, 2'b01);
    set_tx(16'h0006, '{OP_WRITE, 8'h50, 8'h01, 8'h00, 8'hAA, 8'hBB}, 5, 2'b01);
    chk(16'(i2c_busy), 16'h0);
    s_write();
    s_nak();
    s_read();
    set_tx(16'h0004, '{OP_READ, 8'h50, 8'h01, 8'h00}, 4, 2'b10);
    tick(1000);
    suspend_l2 = 1'b1;
    tick(2);
    chk(16'(hid_suspended), 16'h1);
    setup = '{RT_SET, 8'h0A, 16'h0000, WIDX_HID, 16'h0000};
    pulse(setup_valid);
    chk(16'(setup_stall), 16'h0);
    wait_idle();
    suspend_l2 = 1'b0;
    tick(2);
    chk(16'(hid_suspended), 16'h0);
    get_rep(1'b0, '{ST_TIMEOUT, 8'h01, 8'h00, 8'h5C});
    print_verdict();
  end
  // The full sequence needs about 51000 cycles.
  initial begin
    #360000;
    n_mismatch++;
    print_verdict();
  end
endmodule : uhb_bridge_bench
`default_nettype wire
